// ===== rtl/adc_result_config_registers.sv
// Pointer, result, configuration and limit registers of the converter
// Operation
// - Result is a 12-bit two's complement code, left justified in 16.
// - Positive full scale gives 7ff0, negative full scale gives 8000.
// - Codes beyond full scale saturate instead of wrapping.
// - Zero is 0000, one step up 0010, one step down fff0.
// - Pointer byte written first selects target of later accesses.
// - Select 00 result, 01 config, 10 low limit, 11 high limit.
// - Result is zero after power-up until first conversion completes.
// - Result bits sit in 15:4; bits 3:0 read zero.
// - Result register is read-only, holds the latest conversion.
// - Config selected by pointer 1, resets to 8583.
// - Config sets mode and input, reports busy status when read.
// - Config fields: start, input, gain, mode, rate, alert bits.
// - Limit registers exist only in variants with the comparator.
// - Pointer select is retained until a new pointer byte arrives.
// - Words move as two bytes, most significant first.
`timescale 1ns/1ps
`include "adc_regs_defines.svh"
module adc_result_config_registers #(
    parameter bit HAS_COMPARATOR = 1'b1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Register access from the serial front end, same clock
    input wire adc_regs_pkg::reg_req_t req,
    // Finished conversion from the converter core, same clock
    input wire adc_regs_pkg::conv_in_t conv,
    // Read data for the selected register, MSB byte is [15:8]
    output logic [15:0] read_word,
    // Current pointer select
    output logic [1:0] sel,
    // Single-shot start pulse toward the converter core
    output logic start_pulse,
    // Configuration fields toward the converter core
    output logic [2:0] input_select,
    output logic [2:0] gain_range,
    output logic continuous_n,
    output logic [2:0] sample_rate_sel,
    output logic alert_window,
    output logic alert_polarity,
    output logic alert_latch_en,
    output logic [1:0] alert_queue_sel
);
    import adc_regs_pkg::*;

    // ****************************************************
    // State
    // ****************************************************
    logic [1:0] sel_reg, sel_next;
    logic [15:0] result_reg, result_next;
    logic [14:0] cfg_reg, cfg_next;
    logic [15:0] low_reg, low_next, high_reg, high_next;
    logic [15:0] rd_reg, rd_next;
    logic start_reg, start_next;
    conv_state_t st_reg, st_next;
    logic [15:0] clipped;

    // Clip the raw code, then shift it into the top twelve bits
    always_comb
    begin
        if (conv.raw > `RAW_POS_MAX)
            clipped = `CODE_POS_FS;
        else if (conv.raw < `RAW_NEG_MIN)
            clipped = `CODE_NEG_FS;
        else
            clipped = {conv.raw[11:0], 4'h0};
    end

    // Next values of all registers
    always_comb
    begin
        sel_next = sel_reg;
        result_next = result_reg;
        cfg_next = cfg_reg;
        low_next = low_reg;
        high_next = high_reg;
        start_next = 1'b0;
        st_next = st_reg;
        // Upper pointer bits are don't-care by design
        if (req.ptr_wr)
            sel_next = req.ptr_byte[1:0];
        // Data write lands in the register already selected
        if (req.data_wr)
        begin
            case (sel_reg)
                `SEL_CONFIG:
                begin
                    cfg_next = req.data_word[14:0];
                    // Start only takes effect while idle
                    if (req.data_word[`CFG_START_BIT] && st_reg == idle_st)
                        start_next = 1'b1;
                end
                `SEL_LOW_LIMIT:
                    if (HAS_COMPARATOR)
                        low_next = req.data_word;
                `SEL_HIGH_LIMIT:
                    if (HAS_COMPARATOR)
                        high_next = req.data_word;
                default:
                    ; // Result ignores writes
            endcase
        end
        // Busy tracking for the status bit
        case (st_reg)
            idle_st:
                if (start_next)
                    st_next = busy_st;
            busy_st:
                if (conv.valid)
                    st_next = idle_st;
            default:
                st_next = idle_st;
        endcase
        if (conv.valid)
            result_next = clipped;
        // Registered read mux; word goes out MSB byte first
        case (sel_next)
            `SEL_RESULT:
                rd_next = result_next;
            `SEL_CONFIG:
                rd_next = {st_next == idle_st, cfg_next};
            `SEL_LOW_LIMIT:
                rd_next = HAS_COMPARATOR ? low_next : 16'h0000;
            default:
                rd_next = HAS_COMPARATOR ? high_next : 16'h0000;
        endcase
    end

    // Register everything
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            sel_reg <= `SEL_RESULT;
            result_reg <= `RESULT_RESET;
            cfg_reg <= `CONFIG_FIELDS_RESET; // low bits of reset value
            low_reg <= `LOW_LIMIT_RESET;
            high_reg <= `HIGH_LIMIT_RESET;
            rd_reg <= `RESULT_RESET;
            start_reg <= 1'b0;
            st_reg <= idle_st;
        end
        else
        begin
            sel_reg <= sel_next;
            result_reg <= result_next;
            cfg_reg <= cfg_next;
            low_reg <= low_next;
            high_reg <= high_next;
            rd_reg <= rd_next;
            start_reg <= start_next;
            st_reg <= st_next;
        end
    end

    // Outputs straight from flip-flops
    assign read_word = rd_reg;
    assign sel = sel_reg;
    assign start_pulse = start_reg;
    assign input_select = cfg_reg[14:12];
    assign gain_range = cfg_reg[11:9];
    assign continuous_n = cfg_reg[`CFG_MODE_BIT];
    assign sample_rate_sel = cfg_reg[7:5];
    assign alert_window = cfg_reg[4];
    assign alert_polarity = cfg_reg[3];
    assign alert_latch_en = cfg_reg[2];
    assign alert_queue_sel = cfg_reg[1:0];

    // ****************************************************
    // Checks
    // ****************************************************
    clip_pos_a: assert property (
        @(posedge clock) disable iff (!resetn)
        conv.valid && conv.raw > `RAW_POS_MAX |=> result_reg == `CODE_POS_FS)
        else $error("positive clip wrong");
    clip_neg_a: assert property (
        @(posedge clock) disable iff (!resetn)
        conv.valid && conv.raw < `RAW_NEG_MIN |=> result_reg == `CODE_NEG_FS)
        else $error("negative clip wrong");
    low_nibble_a: assert property (
        @(posedge clock) disable iff (!resetn)
        result_reg[3:0] == 4'h0)
        else $error("result low bits set");
    result_hold_a: assert property (
        @(posedge clock) disable iff (!resetn)
        !conv.valid |=> $stable(result_reg))
        else $error("result changed without conversion");
    ptr_keep_a: assert property (
        @(posedge clock) disable iff (!resetn)
        !req.ptr_wr |=> sel_reg == $past(sel_reg))
        else $error("pointer changed");
    ptr_load_a: assert property (
        @(posedge clock) disable iff (!resetn)
        req.ptr_wr |=> sel_reg == $past(req.ptr_byte[1:0]))
        else $error("pointer not loaded");
    cfg_read_a: assert property (
        @(posedge clock) disable iff (!resetn)
        sel_reg == `SEL_CONFIG |-> rd_reg == {st_reg == idle_st, cfg_reg})
        else $error("config readback wrong");
    result_read_a: assert property (
        @(posedge clock) disable iff (!resetn)
        sel_reg == `SEL_RESULT |-> rd_reg == result_reg)
        else $error("result readback wrong");
    step_code_a: assert property (
        @(posedge clock) disable iff (!resetn)
        conv.valid && conv.raw == -14'sh0001 |=> result_reg == 16'hfff0)
        else $error("negative step code wrong");
    busy_hold_a: assert property (
        @(posedge clock) disable iff (!resetn)
        st_reg == busy_st && !conv.valid |=> st_reg == busy_st)
        else $error("busy status dropped early");
    start_idle_a: assert property (
        @(posedge clock) disable iff (!resetn)
        start_reg |-> $past(st_reg) == idle_st)
        else $error("start accepted while busy");
    limit_gate_a: assert property (
        @(posedge clock) disable iff (!resetn)
        !HAS_COMPARATOR && sel_reg[1] |-> rd_reg == 16'h0000)
        else $error("missing limit register read nonzero");
endmodule

// ===== rtl/adc_regs_defines.svh
// Register offsets, field positions, reset values and code limits
`ifndef ADC_REGS_DEFINES_SVH
`define ADC_REGS_DEFINES_SVH
`define SEL_RESULT 2'h0
`define SEL_CONFIG 2'h1
`define SEL_LOW_LIMIT 2'h2
`define SEL_HIGH_LIMIT 2'h3
`define RESULT_RESET 16'h0000
`define CONFIG_RESET 16'h8583
`define CONFIG_FIELDS_RESET 15'h0583
`define LOW_LIMIT_RESET 16'h8000
`define HIGH_LIMIT_RESET 16'h7ff0
`define CODE_POS_FS 16'h7ff0
`define CODE_NEG_FS 16'h8000
`define CODE_LSB_SHIFT 4
`define RAW_POS_MAX 14'sh07ff
`define RAW_NEG_MIN -14'sh0800
`define CFG_START_BIT 15
`define CFG_MODE_BIT 8
`endif

// ===== rtl/adc_regs_pkg.sv
// Types shared by the converter register bank
package adc_regs_pkg;
    // Access request from the serial front end
    typedef struct packed {
        logic ptr_wr;
        logic [7:0] ptr_byte;
        logic data_wr;
        logic [15:0] data_word;
    } reg_req_t;
    // One finished conversion, wide signed raw code before clipping
    typedef struct packed {
        logic valid;
        logic signed [13:0] raw;
    } conv_in_t;
    typedef enum logic [1:0] {idle_st, busy_st} conv_state_t;
endpackage

// ===== testbench/reg_master_model.sv
// Serial bus master stand-in that drives pointer and data write pulses
`timescale 1ns/1ps
module reg_master_model (
    // Clock
    input wire logic clock,
    // Requests toward the register bank
    output adc_regs_pkg::reg_req_t req
);
    import adc_regs_pkg::*;
    initial req = '0;
    // Pointer byte first; released byte lines show garbage, not old data
    task automatic set_ptr(input logic [7:0] p);
        @(posedge clock);
        #1 req.ptr_wr = 1'b1;
        req.ptr_byte = p;
        @(posedge clock);
        #1 req.ptr_wr = 1'b0;
        req.ptr_byte = ~p;
    endtask
    // Word arrives already paired, most significant byte in 15:8
    task automatic write_word(input logic [15:0] w);
        @(posedge clock);
        #1 req.data_wr = 1'b1;
        req.data_word = w;
        @(posedge clock);
        #1 req.data_wr = 1'b0;
        req.data_word = ~w;
    endtask
endmodule

// ===== testbench/test_adc_result_config_registers.sv
// Self-checking bench for the converter register bank
`timescale 1ns/1ps
module test_adc_result_config_registers;
    import adc_regs_pkg::*;
    typedef struct packed {logic signed [13:0] raw; logic [15:0] exp;} row_t;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    reg_req_t req;
    conv_in_t conv = '0;
    logic [15:0] read_word;
    logic [1:0] sel;
    logic start_pulse, continuous_n, alert_window, alert_polarity;
    logic alert_latch_en;
    logic [2:0] input_select, gain_range, sample_rate_sel;
    logic [1:0] alert_queue_sel;
    logic [15:0] cfg_fields, lite_word;
    int n_fail = 0;
    int n_compared = 0;
    // Codes around zero and beyond both full-scale ends
    row_t rows [8] = '{'{14'sd0, 16'h0000}, '{14'sd1, 16'h0010},
        '{-14'sd1, 16'hfff0}, '{14'sd2047, 16'h7ff0}, '{14'sd3000, 16'h7ff0},
        '{-14'sd2048, 16'h8000}, '{-14'sd5000, 16'h8000},
        '{14'sd100, 16'h0640}};
    reg_master_model i_reg_master_model (.clock(clock), .req(req));
    adc_result_config_registers i_adc_result_config_registers (
        .clock(clock), .resetn(resetn), .req(req), .conv(conv),
        .read_word(read_word), .sel(sel), .start_pulse(start_pulse),
        .input_select(input_select), .gain_range(gain_range),
        .continuous_n(continuous_n), .sample_rate_sel(sample_rate_sel),
        .alert_window(alert_window), .alert_polarity(alert_polarity),
        .alert_latch_en(alert_latch_en), .alert_queue_sel(alert_queue_sel));
    // Reduced variant without limit registers, fed the same stimulus
    adc_result_config_registers #(.HAS_COMPARATOR(1'b0))
        i_adc_result_config_registers_lite (
        .clock(clock), .resetn(resetn), .req(req), .conv(conv),
        .read_word(lite_word), .sel(), .start_pulse(), .input_select(),
        .gain_range(), .continuous_n(), .sample_rate_sel(), .alert_window(),
        .alert_polarity(), .alert_latch_en(), .alert_queue_sel());
    assign cfg_fields = {1'b0, input_select, gain_range, continuous_n,
        sample_rate_sel, alert_window, alert_polarity, alert_latch_en,
        alert_queue_sel};
    initial forever #25 clock = ~clock;
    task automatic chk(input string nm, input logic [15:0] got, exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask
    // Conversion done pulse; raw lines scrambled once released
    task automatic conv_done(input logic signed [13:0] r);
        @(posedge clock);
        #1 conv = {1'b1, r};
        @(posedge clock);
        #1 conv = {1'b0, ~r};
    endtask
    task automatic give_verdict;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Hang guard: the whole sequence needs well under 200 cycles
    initial
    begin
        repeat (3000) @(posedge clock);
        n_fail++;
        give_verdict();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (5) @(posedge clock);
        #1 resetn = 1'b1;
        chk("sel", {14'h0, sel}, 16'h0000);
        chk("result", read_word, 16'h0000);
        i_reg_master_model.set_ptr(8'h01);
        chk("config", read_word, 16'h8583);
        chk("fields", cfg_fields, 16'h0583);
        // Upper pointer bits set on purpose: the bank must ignore them
        i_reg_master_model.set_ptr(8'hfe);
        chk("low", read_word, 16'h8000);
        chk("lite low", lite_word, 16'h0000);
        i_reg_master_model.set_ptr(8'hff);
        i_reg_master_model.write_word(16'h1230);
        chk("high", read_word, 16'h1230);
        chk("lite high", lite_word, 16'h0000);
        chk("sel3", {14'h0, sel}, 16'h0003);
        i_reg_master_model.set_ptr(8'h01);
        i_reg_master_model.write_word(16'hc383);
        chk("start", {15'h0, start_pulse}, 16'h0001);
        chk("busy", read_word, 16'h4383);
        i_reg_master_model.write_word(16'hc383);
        chk("restart", {15'h0, start_pulse}, 16'h0000);
        i_reg_master_model.set_ptr(8'h00);
        foreach (rows[i])
        begin
            conv_done(rows[i].raw);
            chk("code", read_word, rows[i].exp);
        end
        i_reg_master_model.write_word(16'h1234);
        chk("ro", read_word, 16'h0640);
        i_reg_master_model.set_ptr(8'h01);
        chk("idle", read_word, 16'hc383);
        // Start bit clear, every other field moved off its reset value
        i_reg_master_model.write_word(16'h7a5c);
        chk("cfgw", read_word, 16'hfa5c);
        chk("fields2", cfg_fields, 16'h7a5c);
        resetn = 1'b0;
        @(posedge clock);
        #1 chk("rst", read_word, 16'h0000);
        chk("rst sel", {14'h0, sel}, 16'h0000);
        chk("rst fields", cfg_fields, 16'h0583);
        resetn = 1'b1;
        i_reg_master_model.set_ptr(8'h01);
        chk("cfg2", read_word, 16'h8583);
        give_verdict();
    end
endmodule
